//--- psq_consts.svh
// constants of the power sequencer and its host end
// assumes a 10 MHz mclk and one open-drain control bus
//
// Contract
// - all_rails_good high only after every rail
// - button event raises the host wake input
// - button press asserts the interrupt line
// - interrupt pin only pulls low, else released
// - always-on rtc rail enabled before all others
// - aux 3.3 V rail only after main 3.3
// - slots: 15 first, then 1 up to 5
// - led on only after complete power-up; the code also lights it for the fault flash while sequencing
// - fault after start: shut down, single flash
// - at power-in only rtc ldo is on
// - rtc good releases host rtc domain reset
// - host raises power request after rtc stable
// - control bus switches rails and sets voltages
// - cpu rail defaults 1.1 V, host may raise
// - host never reprograms fixed core rail
// - dram 1.5 V; 1.35 V for low-voltage parts
// - rtc-only mode keeps only rtc rail on
// - rtc-plus-memory mode keeps rtc and dram rails
// - host puts memory in self refresh first
// - host lowers cpu voltage with its clock
// - request low starts the power-down
// - button held over 8 s powers down alone
`ifndef PSQ_CONSTS_SVH
`define PSQ_CONSTS_SVH
`define PSQ_NRAIL 8
`define PSQ_R_RTC 0
`define PSQ_R_MAIN33 4
`define PSQ_R_AUX 7
`define PSQ_M_RTC 8'h01
`define PSQ_M_AUX 8'h80
`define PSQ_M_S1 8'h03
`define PSQ_M_S2 8'h07
`define PSQ_M_S3 8'h0f
`define PSQ_M_S4 8'h1f
`define PSQ_M_S5 8'h7f
`define PSQ_M_ALL 8'hff
`define PSQ_SLOT_RTC 4'hf
`define PSQ_SLOT_FIRST 4'h1
`define PSQ_SLOT_AUX 4'h4
`define PSQ_SLOT_LAST 4'h5
`define PSQ_I2C_ADDR 7'h2a
`define PSQ_REG_MASK 8'h00
`define PSQ_REG_CPU_V 8'h01
`define PSQ_REG_DRAM_V 8'h02
`define PSQ_REG_EVT 8'h03
`define PSQ_V_1V1 8'h6e
`define PSQ_V_1V5 8'h96
`define PSQ_V_1V35 8'h87
`define PSQ_MASK_RTC_ONLY 8'h01
`define PSQ_MASK_RTC_DRAM 8'h03
`define PSQ_WB_CTRL 4'h0
`define PSQ_WB_CMD 4'h4
`define PSQ_WB_STATUS 4'h8
`define PSQ_CLK_HZ 10000000
`define PSQ_TICK_CYC (`PSQ_CLK_HZ / 1000)
`define PSQ_HOLD_MS 8000
`define PSQ_FLASH_MS 200
`define PSQ_SLOT_TMO_MS 50
`define PSQ_I2C_HZ 100000
`define PSQ_QTR_CYC (`PSQ_CLK_HZ / (`PSQ_I2C_HZ * 4))
`define PSQ_FRAME_BITS 27
`endif

//--- psq_pkg.sv
// types shared by the sequencer and the host end
// assumes nothing beyond the state names below
package psq_pkg;
  typedef enum logic [2:0] {PSQ_S_RTC, PSQ_S_IDLE, PSQ_S_SEQ, PSQ_S_UP, PSQ_S_FLASH, PSQ_S_OFF} psq_state_t;
  typedef enum logic [1:0] {PSQ_H_IDLE, PSQ_H_START, PSQ_H_BIT, PSQ_H_STOP} psq_hstate_t;
endpackage

//--- psq_if.sv
// wires between sequencer and host
// open-drain lines resolve here against an implied pull-up
`timescale 1ns/1ps
`default_nettype none
interface psq_if;
  logic power_on_request;
  logic ldo_good_flag;
  logic all_rails_good;
  logic external_wake_input;
  logic dev_irq_o;
  logic dev_irq_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire power_ctrl_irq;
  wire scl;
  wire sda;
  assign power_ctrl_irq = ~(dev_irq_oe & ~dev_irq_o);
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);
  modport dev (input power_on_request, scl, sda, output ldo_good_flag, all_rails_good,
    external_wake_input, dev_irq_o, dev_irq_oe, dev_sda_o, dev_sda_oe);
  modport host (input ldo_good_flag, all_rails_good, external_wake_input, power_ctrl_irq, scl, sda,
    output power_on_request, host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface
`default_nettype wire

//--- psq_tick.sv
// one-cycle enable every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module psq_tick #(parameter int DIV = 10000) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // enable out
  output logic tick
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt;
  always_ff @(posedge mclk)
  begin
    if (rst || cnt == W'(DIV - 1))
      cnt <= '0;
    else
      cnt <= cnt + W'(1);
  end
  always_ff @(posedge mclk)
  begin
    tick <= !rst && cnt == W'(DIV - 1);
  end
endmodule // psq_tick
`default_nettype wire

//--- psq_sequencer.sv
// power sequencer: rail slots, reset releases, button events, control-bus target
// assumes rail good inputs and button are synchronous to mclk
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psq_consts.svh"
module psq_sequencer #(
  parameter int TICK_CYC = `PSQ_TICK_CYC,
  parameter int HOLD_MS = `PSQ_HOLD_MS,
  parameter int FLASH_MS = `PSQ_FLASH_MS,
  parameter int TMO_MS = `PSQ_SLOT_TMO_MS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link to host
  psq_if.dev ifc,
  // rails
  input wire logic [`PSQ_NRAIL-1:0] rail_good,
  output logic [`PSQ_NRAIL-1:0] rail_en,
  output logic [7:0] cpu_vcode,
  output logic [7:0] dram_vcode,
  // board
  input wire logic pwr_button,
  input wire logic dram_low_voltage,
  output logic power_led
);
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] slot_cum(input logic [3:0] s);
    case (s)
      4'h1: slot_cum = `PSQ_M_S1;
      4'h2: slot_cum = `PSQ_M_S2;
      4'h3: slot_cum = `PSQ_M_S3;
      4'h4: slot_cum = `PSQ_M_S4;
      4'h5: slot_cum = `PSQ_M_S5;
      default: slot_cum = `PSQ_M_RTC;
    endcase
  endfunction
  // slots at or past the aux slot also need the aux rail
  function automatic logic [7:0] slot_need(input logic [3:0] s);
    slot_need = slot_cum(s) | ((s >= `PSQ_SLOT_AUX && s != `PSQ_SLOT_RTC) ? `PSQ_M_AUX : 8'h00);
  endfunction

  psq_pkg::psq_state_t state;
  logic ms_tick;
  logic [3:0] slot;
  logic [15:0] ms_cnt;
  logic [15:0] hold_ms;
  logic long_press;
  logic btn_q;
  logic evt_pend;
  logic [7:0] rail_mask;
  logic [7:0] good_q;
  logic [7:0] next_en;
  logic [7:0] need;
  logic slot_ok;
  logic rail_fault;
  logic scl_q;
  logic sda_q;
  logic active;
  logic [3:0] bitcnt;
  logic [1:0] byte_idx;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic wr_stb;
  logic [7:0] wr_reg;
  logic [7:0] wr_dat;
  logic press;
  logic start_c;
  logic stop_c;

  psq_tick #(.DIV(TICK_CYC)) u_tick (.mclk(mclk), .rst(rst), .tick(ms_tick));

  ////////////////////////////////////////////////////////////////
  // button events and long hold
  assign press = pwr_button && !btn_q;
  always_ff @(posedge mclk)
  begin
    btn_q <= rst ? 1'b0 : pwr_button;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      evt_pend <= 1'b0;
    else if (press)
      evt_pend <= 1'b1;
    else if (wr_stb && wr_reg == `PSQ_REG_EVT && wr_dat[0])
      evt_pend <= 1'b0;
  end
  always_ff @(posedge mclk)
  begin
    ifc.dev_irq_o <= 1'b0;
    ifc.dev_irq_oe <= !rst && (evt_pend || press);
    ifc.external_wake_input <= !rst && (evt_pend || press);
  end
  always_ff @(posedge mclk)
  begin
    if (rst || !pwr_button)
    begin
      hold_ms <= '0;
      long_press <= 1'b0;
    end
    else if (ms_tick && !long_press)
    begin
      hold_ms <= hold_ms + 16'h0001;
      long_press <= hold_ms == 16'(HOLD_MS);
    end
  end

  ////////////////////////////////////////////////////////////////
  // sequencing
  assign need = slot_need(slot);
  assign slot_ok = (rail_good & need) == need;
  // only rails seen good before count as lost, so a rail just switched on is not a fault
  assign rail_fault = |(rail_en & good_q & ~rail_good);

  always_comb
  begin
    next_en = `PSQ_M_RTC;
    case (state)
      psq_pkg::PSQ_S_SEQ:
        next_en = slot_cum(slot) | ((slot >= `PSQ_SLOT_AUX && rail_good[`PSQ_R_MAIN33]) ? `PSQ_M_AUX : 8'h00);
      psq_pkg::PSQ_S_UP:
      begin
        next_en = (slot_cum(`PSQ_SLOT_LAST) & rail_mask) | `PSQ_M_RTC;
        if (rail_mask[`PSQ_R_AUX] && rail_mask[`PSQ_R_MAIN33] && rail_good[`PSQ_R_MAIN33])
          next_en = next_en | `PSQ_M_AUX;
      end
      default: next_en = `PSQ_M_RTC;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    rail_en <= rst ? `PSQ_M_RTC : next_en;
    good_q <= rst ? 8'h00 : rail_good;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= psq_pkg::PSQ_S_RTC;
      slot <= `PSQ_SLOT_RTC;
      ms_cnt <= '0;
      ifc.ldo_good_flag <= 1'b0;
      ifc.all_rails_good <= 1'b0;
      power_led <= 1'b0;
    end
    else
    begin
      if (ms_tick)
        ms_cnt <= ms_cnt + 16'h0001;
      case (state)
        psq_pkg::PSQ_S_RTC:
          if (rail_good[`PSQ_R_RTC])
          begin
            ifc.ldo_good_flag <= 1'b1;
            state <= psq_pkg::PSQ_S_IDLE;
          end
        psq_pkg::PSQ_S_IDLE:
        begin
          slot <= `PSQ_SLOT_FIRST;
          ms_cnt <= '0;
          if (ifc.power_on_request)
            state <= psq_pkg::PSQ_S_SEQ;
        end
        psq_pkg::PSQ_S_SEQ:
          if (!ifc.power_on_request)
            state <= psq_pkg::PSQ_S_IDLE;
          else if (ms_cnt == 16'(TMO_MS) || rail_fault)
          begin
            power_led <= 1'b1;
            ms_cnt <= '0;
            state <= psq_pkg::PSQ_S_FLASH;
          end
          else if (slot_ok && rail_en == (slot_cum(slot) | (need & `PSQ_M_AUX)))
          begin
            ms_cnt <= '0;
            if (slot == `PSQ_SLOT_LAST)
            begin
              ifc.all_rails_good <= 1'b1;
              power_led <= 1'b1;
              state <= psq_pkg::PSQ_S_UP;
            end
            else
              slot <= slot + 4'h1;
          end
        psq_pkg::PSQ_S_UP:
          if (!ifc.power_on_request || long_press)
          begin
            ifc.all_rails_good <= 1'b0;
            power_led <= 1'b0;
            state <= psq_pkg::PSQ_S_OFF;
          end
          else if (rail_fault)
          begin
            ifc.all_rails_good <= 1'b0;
            ms_cnt <= '0;
            state <= psq_pkg::PSQ_S_FLASH;
          end
        psq_pkg::PSQ_S_FLASH:
          if (ms_cnt == 16'(FLASH_MS))
          begin
            power_led <= 1'b0;
            state <= psq_pkg::PSQ_S_OFF;
          end
        psq_pkg::PSQ_S_OFF:
          if (!ifc.power_on_request)
            state <= psq_pkg::PSQ_S_IDLE;
        default: state <= psq_pkg::PSQ_S_RTC;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // control-bus target, write only: address, register pointer, data
  assign start_c = ifc.scl && scl_q && sda_q && !ifc.sda;
  assign stop_c = ifc.scl && scl_q && !sda_q && ifc.sda;
  always_ff @(posedge mclk)
  begin
    scl_q <= rst ? 1'b1 : ifc.scl;
    sda_q <= rst ? 1'b1 : ifc.sda;
  end
  always_ff @(posedge mclk)
  begin
    wr_stb <= 1'b0;
    ifc.dev_sda_o <= 1'b0;
    if (rst || stop_c)
    begin
      active <= 1'b0;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
      ifc.dev_sda_oe <= 1'b0;
    end
    else if (start_c)
    begin
      active <= 1'b1;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
    end
    else if (active && ifc.scl && !scl_q && bitcnt < 4'h8)
    begin
      shreg <= {shreg[6:0], ifc.sda};
      bitcnt <= bitcnt + 4'h1;
    end
    else if (active && !ifc.scl && scl_q)
    begin
      if (bitcnt == 4'h8)
      begin
        bitcnt <= 4'h9;
        ifc.dev_sda_oe <= 1'b1;
        if (byte_idx == 2'h0 && shreg != {`PSQ_I2C_ADDR, 1'b0})
        begin
          active <= 1'b0;
          ifc.dev_sda_oe <= 1'b0;
        end
        else if (byte_idx == 2'h1)
          ptr <= shreg;
        else if (byte_idx == 2'h2)
        begin
          wr_stb <= 1'b1;
          wr_reg <= ptr;
          wr_dat <= shreg;
        end
      end
      else if (bitcnt == 4'h9)
      begin
        ifc.dev_sda_oe <= 1'b0;
        bitcnt <= 4'h0;
        if (byte_idx != 2'h2)
          byte_idx <= byte_idx + 2'h1;
      end
    end
  end

  // core rail has no voltage register: it stays fixed at its default
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rail_mask <= `PSQ_M_ALL;
      cpu_vcode <= `PSQ_V_1V1;
      dram_vcode <= `PSQ_V_1V5;
    end
    else if (wr_stb)
    begin
      if (wr_reg == `PSQ_REG_MASK)
        rail_mask <= wr_dat | `PSQ_M_RTC;
      if (wr_reg == `PSQ_REG_CPU_V)
        cpu_vcode <= wr_dat;
      if (wr_reg == `PSQ_REG_DRAM_V && (wr_dat == `PSQ_V_1V5 || (wr_dat == `PSQ_V_1V35 && dram_low_voltage)))
        dram_vcode <= wr_dat;
    end
  end
endmodule // psq_sequencer
`default_nettype wire

//--- psq_host.sv
// host end: wishbone registers, power request, control-bus master
// assumes a classic wishbone master on the software side
`timescale 1ns/1ps
`default_nettype none
`include "psq_consts.svh"
module psq_host #(parameter int QTR_CYC = `PSQ_QTR_CYC) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link to sequencer
  psq_if.host ifc,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // host side
  output logic processor_por_reset_n,
  output logic rtc_domain_reset_n,
  output logic dram_self_refresh,
  output logic host_irq
);
  psq_pkg::psq_hstate_t hs;
  logic qt;
  logic req_bit;
  logic busy;
  logic nack;
  logic [1:0] phase;
  logic [4:0] bitpos;
  logic [`PSQ_FRAME_BITS-1:0] frame;
  logic go;
  logic [15:0] go_word;
  logic req;
  logic take;
  logic [1:0] mode;

  psq_tick #(.DIV(QTR_CYC)) u_qtr (.mclk(mclk), .rst(rst), .tick(qt));

  ////////////////////////////////////////////////////////////////
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign mode = wb_dat_i[2:1];
  // writes land at the edge where the master sees ack, not when the request first appears
  assign take = wb_cyc_i && wb_stb_i && wb_ack_o;
  always_ff @(posedge mclk)
  begin
    wb_ack_o <= !rst && req;
    wb_dat_o <= (req && wb_adr_i == `PSQ_WB_STATUS) ?
      {26'h0, ifc.ldo_good_flag, ifc.all_rails_good, ifc.external_wake_input, !ifc.power_ctrl_irq, nack, busy} :
      (req && wb_adr_i == `PSQ_WB_CTRL) ? {28'h0, dram_self_refresh, 2'h0, req_bit} : 32'h0;
  end
  always_ff @(posedge mclk)
  begin
    go <= 1'b0;
    if (rst)
    begin
      req_bit <= 1'b0;
      dram_self_refresh <= 1'b0;
      go_word <= 16'h0;
    end
    else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == `PSQ_WB_CTRL)
    begin
      req_bit <= wb_dat_i[0];
      dram_self_refresh <= mode == 2'h2;
      if (mode != 2'h0 && !busy)
      begin
        go <= 1'b1;
        go_word <= {`PSQ_REG_MASK, (mode == 2'h2) ? `PSQ_MASK_RTC_DRAM : `PSQ_MASK_RTC_ONLY};
      end
    end
    else if (take && wb_we_i && &wb_sel_i[1:0] && wb_adr_i == `PSQ_WB_CMD && !busy)
    begin
      go <= 1'b1;
      go_word <= wb_dat_i[15:0];
    end
  end
  always_ff @(posedge mclk)
  begin
    ifc.power_on_request <= !rst && req_bit && ifc.ldo_good_flag;
    processor_por_reset_n <= !rst && ifc.all_rails_good;
    rtc_domain_reset_n <= !rst && ifc.ldo_good_flag;
    host_irq <= !rst && !ifc.power_ctrl_irq;
  end

  ////////////////////////////////////////////////////////////////
  // write frame: address, pointer, data, each followed by a released ack bit
  always_ff @(posedge mclk)
  begin
    ifc.host_scl_o <= 1'b0;
    ifc.host_sda_o <= 1'b0;
    if (rst)
    begin
      hs <= psq_pkg::PSQ_H_IDLE;
      busy <= 1'b0;
      nack <= 1'b0;
      phase <= 2'h0;
      bitpos <= 5'h0;
      ifc.host_scl_oe <= 1'b0;
      ifc.host_sda_oe <= 1'b0;
    end
    else if (go)
    begin
      hs <= psq_pkg::PSQ_H_START;
      busy <= 1'b1;
      nack <= 1'b0;
      phase <= 2'h0;
      bitpos <= 5'h0;
      frame <= {`PSQ_I2C_ADDR, 1'b0, 1'b1, go_word[15:8], 1'b1, go_word[7:0], 1'b1};
    end
    else if (qt)
    begin
      phase <= phase + 2'h1;
      case (hs)
        psq_pkg::PSQ_H_START:
        begin
          if (phase == 2'h0)
            ifc.host_sda_oe <= 1'b1;
          if (phase == 2'h1)
          begin
            ifc.host_scl_oe <= 1'b1;
            phase <= 2'h0;
            hs <= psq_pkg::PSQ_H_BIT;
          end
        end
        psq_pkg::PSQ_H_BIT:
          case (phase)
            2'h0: ifc.host_sda_oe <= !frame[`PSQ_FRAME_BITS-1];
            2'h1: ifc.host_scl_oe <= 1'b0;
            2'h2:
              if ((bitpos == 5'h08 || bitpos == 5'h11 || bitpos == 5'h1a) && ifc.sda)
                nack <= 1'b1;
            default:
            begin
              ifc.host_scl_oe <= 1'b1;
              frame <= {frame[`PSQ_FRAME_BITS-2:0], 1'b1};
              bitpos <= bitpos + 5'h1;
              if (bitpos == 5'(`PSQ_FRAME_BITS - 1))
                hs <= psq_pkg::PSQ_H_STOP;
            end
          endcase
        psq_pkg::PSQ_H_STOP:
          case (phase)
            2'h0: ifc.host_sda_oe <= 1'b1;
            2'h1: ifc.host_scl_oe <= 1'b0;
            2'h2:
            begin
              ifc.host_sda_oe <= 1'b0;
              busy <= 1'b0;
              hs <= psq_pkg::PSQ_H_IDLE;
            end
            default: phase <= 2'h0;
          endcase
        default: phase <= 2'h0;
      endcase
    end
  end
endmodule // psq_host
`default_nettype wire

//--- psq_chk.sv
// checker for the link between the sequencer and the host end
// instantiated in the bench top beside the link interface; one clock, one reset
`timescale 1ns/1ps
`default_nettype none
module psq_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link signals
  input wire logic power_on_request,
  input wire logic ldo_good_flag,
  input wire logic all_rails_good,
  input wire logic external_wake_input,
  input wire logic dev_irq_o,
  input wire logic dev_irq_oe,
  // sequencer board side
  input wire logic pwr_button,
  input wire logic power_led,
  input wire logic [7:0] rail_en,
  input wire logic [7:0] rail_good
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_good_after_all: assert property ($rose(all_rails_good) |-> $past(rail_good) == 8'hff && rail_en == 8'hff)
    else $error("all rails good raised too early");
  a_led_with_good: assert property (all_rails_good |-> power_led)
    else $error("led dark while all rails good");
  a_irq_pull_only: assert property (dev_irq_o == 1'h0)
    else $error("interrupt pin driven high");
  a_button_event: assert property ($rose(pwr_button) |=> dev_irq_oe && external_wake_input)
    else $error("button press gave no interrupt or wake");
  a_wake_is_irq: assert property (external_wake_input == dev_irq_oe)
    else $error("wake and interrupt disagree");
  a_rtc_first: assert property (rail_en[7:1] != 7'h00 |-> rail_en[0] && ldo_good_flag)
    else $error("rail on before the rtc rail");
  a_aux_after_main: assert property ($rose(rail_en[7]) |-> $past(rail_good[4]) && rail_en[4])
    else $error("aux rail before main 3v3");
  a_first_slot: assert property ($rose(rail_en[1]) |-> $past(rail_en[7:1]) == 7'h00 && $past(power_on_request))
    else $error("dram slot out of order");
  a_slot_core: assert property ($rose(rail_en[5]) |-> ($past(rail_good) & 8'h9f) == 8'h9f)
    else $error("core slot before earlier slots good");
  a_ldo_follows: assert property ($rose(ldo_good_flag) |-> $past(rail_good[0]))
    else $error("ldo good without rtc rail");
  a_req_needs_ldo: assert property ($rose(power_on_request) |-> $past(ldo_good_flag))
    else $error("power request before rtc stable");
  a_req_drop_off: assert property ($fell(power_on_request) |-> ##[1:4] !all_rails_good)
    else $error("request low did not power down");
  // main scenarios reached
  c_up: cover property ($rose(all_rails_good));
  c_irq: cover property ($rose(dev_irq_oe));
  c_down: cover property ($fell(all_rails_good));
  c_rtc_dram: cover property (rail_en == 8'h03);
endmodule // psq_chk
`default_nettype wire

//--- psq_tb_top.sv
// bench top: sequencer and host joined by the link interface, checker beside it
// assumes the design files are compiled first; short tick counts shorten the run
`timescale 1ns/1ps
`default_nettype none
`include "psq_consts.svh"
module psq_tb_top;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, wb_q;
  logic [7:0] rail_good = 8'h00, kill = 8'h00, rail_en, cpu_vcode, dram_vcode;
  logic pwr_button = 1'h0, dram_low_voltage = 1'h0, led_q = 1'h0;
  logic power_led, processor_por_reset_n, rtc_domain_reset_n, dram_self_refresh, host_irq;
  logic [31:0] lfsr = 32'h0a47;
  int fails = 0, total_checks = 0, cycles = 0, led_rises = 0;
  psq_if link();
  psq_sequencer #(.TICK_CYC(10), .HOLD_MS(20), .FLASH_MS(5), .TMO_MS(10)) psq_sequencer_inst (.mclk(mclk),
    .rst(rst), .ifc(link), .rail_good(rail_good), .rail_en(rail_en), .cpu_vcode(cpu_vcode),
    .dram_vcode(dram_vcode), .pwr_button(pwr_button), .dram_low_voltage(dram_low_voltage), .power_led(power_led));
  psq_host #(.QTR_CYC(4)) psq_host_inst (.mclk(mclk), .rst(rst), .ifc(link), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack), .processor_por_reset_n(processor_por_reset_n), .rtc_domain_reset_n(rtc_domain_reset_n),
    .dram_self_refresh(dram_self_refresh), .host_irq(host_irq));
  psq_chk psq_chk_inst (.mclk(mclk), .rst(rst), .power_on_request(link.power_on_request),
    .ldo_good_flag(link.ldo_good_flag), .all_rails_good(link.all_rails_good),
    .external_wake_input(link.external_wake_input), .dev_irq_o(link.dev_irq_o), .dev_irq_oe(link.dev_irq_oe),
    .pwr_button(pwr_button), .power_led(power_led), .rail_en(rail_en), .rail_good(rail_good));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // classic wishbone cycle: held until ack is sampled, read data taken there
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    @(posedge mclk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack !== 1'h1 && n < 20);
    wb_q = wb_dat_o;
    if (n >= 20)
      check_bit("wb ack", 1'h1, wb_ack);
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
  endtask
  // a whole control-bus frame takes some 450 cycles here, so poll busy
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      wb_xfer(1'h0, `PSQ_WB_STATUS, 32'h0);
      n++;
    end
    while (wb_q[0] !== 1'h0 && n < 300);
    check_bit("busy", 1'h0, wb_q[0]);
    check_bit("nack", 1'h0, wb_q[1]);
  endtask
  task automatic bus_cmd(input logic [7:0] r, input logic [7:0] d);
    wb_xfer(1'h1, `PSQ_WB_CMD, {16'h0, r, d});
    wait_idle();
  endtask
  // request power, wait for all rails, then check the up state
  task automatic power_up();
    int n;
    wb_xfer(1'h1, `PSQ_WB_CTRL, 32'h1);
    for (n = 0; n < 2000 && link.all_rails_good !== 1'h1; n++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    check_bit("led", 1'h1, power_led);
    check_bit("por reset", 1'h1, processor_por_reset_n);
    check_val("rail_en", 32'hff, {24'h0, rail_en});
    wb_xfer(1'h0, `PSQ_WB_STATUS, 32'h0);
    check_val("status", 32'h30, wb_q & 32'h3f);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // rail goods follow enables after a random delay; kill holds a rail down
  always #50 mclk = ~mclk;
  always @(posedge mclk)
  begin
    lfsr <= lfsr_next(lfsr);
    rail_good <= rail_en & (rail_good | lfsr[7:0]) & ~kill;
    led_q <= power_led;
    if (power_led === 1'h1 && led_q === 1'h0)
      led_rises <= led_rises + 1;
    cycles <= cycles + 1;
    if (cycles > 40000)
    begin
      fails++;
      report_and_stop();
    end
  end
  initial
  begin
    int n, r0;
    logic [7:0] v;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    check_val("rail_en", 32'h01, {24'h0, rail_en});
    check_val("cpu code", 32'h6e, {24'h0, cpu_vcode});
    check_val("dram code", 32'h96, {24'h0, dram_vcode});
    check_bit("irq line", 1'h1, link.power_ctrl_irq);
    for (n = 0; n < 100 && link.ldo_good_flag !== 1'h1; n++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    check_bit("rtc reset", 1'h1, rtc_domain_reset_n);
    check_bit("por reset", 1'h0, processor_por_reset_n);
    wb_xfer(1'h0, 4'hc, 32'h0);
    check_val("unmapped", 32'h0, wb_q);
    power_up();
    v = 8'h6f + {4'h0, lfsr[3:0]};
    bus_cmd(`PSQ_REG_CPU_V, v);
    check_val("cpu code", {24'h0, v}, {24'h0, cpu_vcode});
    bus_cmd(`PSQ_REG_CPU_V, `PSQ_V_1V1);
    check_val("cpu code", 32'h6e, {24'h0, cpu_vcode});
    bus_cmd(`PSQ_REG_DRAM_V, `PSQ_V_1V35);
    check_val("dram code", 32'h96, {24'h0, dram_vcode});
    dram_low_voltage <= 1'h1;
    bus_cmd(`PSQ_REG_DRAM_V, `PSQ_V_1V35);
    check_val("dram code", 32'h87, {24'h0, dram_vcode});
    // press shorter than the hold limit: interrupt only, rails stay up
    pwr_button <= 1'h1;
    repeat (150) @(posedge mclk);
    pwr_button <= 1'h0;
    @(posedge mclk);
    check_bit("host irq", 1'h1, host_irq);
    check_bit("irq line", 1'h0, link.power_ctrl_irq);
    check_bit("wake", 1'h1, link.external_wake_input);
    check_bit("good", 1'h1, link.all_rails_good);
    wb_xfer(1'h0, `PSQ_WB_STATUS, 32'h0);
    check_val("status", 32'h3c, wb_q & 32'h3f);
    bus_cmd(`PSQ_REG_EVT, 8'h01);
    @(posedge mclk);
    check_bit("irq line", 1'h1, link.power_ctrl_irq);
    check_bit("wake", 1'h0, link.external_wake_input);
    for (int m = 2; m > 0; m--)
    begin
      wb_xfer(1'h1, `PSQ_WB_CTRL, 32'(m * 2 + 1));
      wait_idle();
      repeat (4) @(posedge mclk);
      check_val("mode rails", (m == 2) ? 32'h03 : 32'h01, {24'h0, rail_en});
      if (m == 2)
        check_bit("self refresh", 1'h1, dram_self_refresh);
      wb_xfer(1'h0, `PSQ_WB_CTRL, 32'h0);
      check_val("ctrl", (m == 2) ? 32'h09 : 32'h01, wb_q);
    end
    wb_xfer(1'h1, `PSQ_WB_CTRL, 32'h0);
    repeat (6) @(posedge mclk);
    check_bit("good", 1'h0, link.all_rails_good);
    check_bit("por reset", 1'h0, processor_por_reset_n);
    check_val("rails off", 32'h0, {25'h0, rail_en[7:1]});
    // the slot-3 rail (bit 3) never comes good: one flash, back to rtc only
    kill <= 8'h08;
    r0 = led_rises;
    wb_xfer(1'h1, `PSQ_WB_CTRL, 32'h1);
    for (n = 0; n < 1000 && led_rises == r0; n++) @(posedge mclk);
    for (n = 0; n < 1000 && power_led !== 1'h0; n++) @(posedge mclk);
    repeat (100) @(posedge mclk);
    check_val("flashes", 32'h1, 32'(led_rises - r0));
    check_val("rail_en", 32'h01, {24'h0, rail_en});
    check_bit("good", 1'h0, link.all_rails_good);
    kill <= 8'h00;
    wb_xfer(1'h1, `PSQ_WB_CTRL, 32'h0);
    repeat (5) @(posedge mclk);
    dram_low_voltage <= 1'h0;
    // full mask back, then a long press with the request still high powers down alone
    bus_cmd(`PSQ_REG_MASK, 8'hff);
    power_up();
    pwr_button <= 1'h1;
    repeat (300) @(posedge mclk);
    check_bit("good", 1'h0, link.all_rails_good);
    check_val("rails off", 32'h0, {25'h0, rail_en[7:1]});
    pwr_button <= 1'h0;
    bus_cmd(`PSQ_REG_EVT, 8'h01);
    report_and_stop();
  end
endmodule // psq_tb_top
`default_nettype wire
